// [tb/cmmd_decoder_monitor.sv]
// Assertion checker on the decoder top-level ports
`timescale 1ns/1ps
`include "cmmd_defs.vh"
module cmmd_decoder_monitor (
    // Clock and reset
    input wire        mclk,
    input wire        sys_rst,
    // Core port
    input wire        accReq,
    input wire [2:0]  accKind,
    input wire        accWrite,
    input wire [15:0] accAddr,
    input wire [7:0]  accRdata,
    input wire        accDone,
    // Special function space port
    input wire        sfsRd,
    input wire        sfsWr,
    input wire [7:0]  sfsAddr,
    input wire [2:0]  sfsBitIdx,
    // Register port and state
    input wire [2:0]  regAddr,
    input wire        regWr,
    input wire        regRd,
    input wire [7:0]  regRdata,
    input wire [7:0]  stackPointer,
    input wire        flashBusy
);
    // Request accepted: no pending special read, no erase running
    wire take = accReq && !sfsRd && !flashBusy;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    stack_reset_a: assert property ($fell(sys_rst) |-> stackPointer == `CMMD_STACK_RESET)
        else $error("stack pointer off after reset");
    push_step_a: assert property (take && accKind == `CMMD_K_PUSH && !(regWr && regAddr == `CMMD_REG_STACK)
        |=> accDone && stackPointer == $past(stackPointer) + 8'h01) else $error("push step wrong");
    space_direct_a: assert property (take && accKind == `CMMD_K_DIRECT && accAddr[7]
        |=> (sfsRd || sfsWr) && sfsAddr == $past(accAddr[7:0])) else $error("direct high not sent out");
    low_direct_a: assert property (take && accKind == `CMMD_K_DIRECT && !accAddr[7]
        |=> accDone && !sfsRd && !sfsWr) else $error("direct low left ram");
    indirect_ram_a: assert property (take && accKind == `CMMD_K_INDIRECT
        |=> accDone && !sfsRd && !sfsWr) else $error("indirect left ram");
    space_done_a: assert property (sfsRd |=> accDone) else $error("special read not completed");
    bit_space_a: assert property (take && accKind == `CMMD_K_BIT && accAddr[7]
        |=> sfsAddr == {$past(accAddr[7:3]), 3'h0} && sfsBitIdx == $past(accAddr[2:0]))
        else $error("bit split wrong");
    code_reserved_a: assert property (take && accKind == `CMMD_K_CODE && accAddr > `CMMD_FLASH_TOP
        |=> accRdata == 8'h00) else $error("reserved code read not zero");
    ext_hole_a: assert property (take && accKind == `CMMD_K_XWIDE && !accWrite && accAddr[9:8] == 2'h3
        |=> accRdata == 8'h00) else $error("hole read not zero");
    page_upper_a: assert property (regRd && regAddr == `CMMD_REG_PAGE
        |=> regRdata[7:2] == 6'h00) else $error("page upper bits set");
endmodule // cmmd_decoder_monitor

bind cmmd_decoder cmmd_decoder_monitor u_cmmd_decoder_monitor (.mclk(mclk), .sys_rst(sys_rst),
    .accReq(accReq), .accKind(accKind), .accWrite(accWrite), .accAddr(accAddr), .accRdata(accRdata),
    .accDone(accDone), .sfsRd(sfsRd), .sfsWr(sfsWr), .sfsAddr(sfsAddr), .sfsBitIdx(sfsBitIdx),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .stackPointer(stackPointer), .flashBusy(flashBusy));

// [tb/cmmd_decoder_tb.sv]
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`include "cmmd_defs.vh"
module cmmd_decoder_tb;
    reg         mclk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         accReq = 1'b0;
    reg  [2:0]  accKind = 3'h0;
    reg         accWrite = 1'b0;
    reg         accRegSel = 1'b0;
    reg  [15:0] accAddr = 16'h0000;
    reg  [7:0]  accWdata = 8'h00;
    reg  [2:0]  regAddr = 3'h0;
    reg  [7:0]  regWdata = 8'h00;
    reg         regWr = 1'b0;
    reg         regRd = 1'b0;
    wire [7:0]  accRdata, sfsAddr, sfsWdata, sfsRdata, regRdata, stackPointer;
    wire        accDone, sfsRd, sfsWr, sfsBitOp, flashBusy;
    wire [2:0]  sfsBitIdx;
    reg  [7:0]  rd;
    integer     error_cnt = 0;
    integer     checks = 0;
    integer     b;

    always #4 mclk = ~mclk;

    cmmd_decoder u_cmmd_decoder (.mclk(mclk), .sys_rst(sys_rst), .accReq(accReq), .accKind(accKind),
        .accWrite(accWrite), .accRegSel(accRegSel), .accAddr(accAddr), .accWdata(accWdata),
        .accRdata(accRdata), .accDone(accDone), .sfsRd(sfsRd), .sfsWr(sfsWr), .sfsBitOp(sfsBitOp),
        .sfsBitIdx(sfsBitIdx), .sfsAddr(sfsAddr), .sfsWdata(sfsWdata), .sfsRdata(sfsRdata),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .stackPointer(stackPointer), .flashBusy(flashBusy));
    cmmd_space_model u_cmmd_space_model (.mclk(mclk), .sfsRd(sfsRd), .sfsWr(sfsWr), .sfsBitOp(sfsBitOp),
        .sfsBitIdx(sfsBitIdx), .sfsAddr(sfsAddr), .sfsWdata(sfsWdata), .sfsRdata(sfsRdata));

    // Compare seen against expected
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One core access, waits for completion
    task acc(input [2:0] kind, input wr, input sel, input [15:0] addr, input [7:0] data);
        integer n;
        begin
            @(posedge mclk);
            accReq <= 1'b1;
            accKind <= kind;
            accWrite <= wr;
            accRegSel <= sel;
            accAddr <= addr;
            accWdata <= data;
            @(posedge mclk);
            accReq <= 1'b0;
            #1;
            n = 0;
            while (accDone !== 1'b1 && n < 4) begin
                @(posedge mclk);
                #1;
                n = n + 1;
            end
            if (n == 4) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t: no completion", $time);
            end
            rd = accRdata;
        end
    endtask
    // Register write
    task rw(input [2:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            regWr <= 1'b1;
            regAddr <= a;
            regWdata <= d;
            @(posedge mclk);
            regWr <= 1'b0;
        end
    endtask
    // Register read, data one cycle later
    task rr(input [2:0] a);
        begin
            @(posedge mclk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge mclk);
            regRd <= 1'b0;
            #1;
            rd = regRdata;
        end
    endtask
    // Counts and verdict
    task summarize;
        begin
            $display("checks %0d errors %0d", checks, error_cnt);
            if (error_cnt == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // Watchdog
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        summarize;
    end

    // Test sequence
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk(stackPointer, `CMMD_STACK_RESET);
        rr(`CMMD_REG_PAGE);
        chk(rd, 8'h00);
        acc(`CMMD_K_PUSH, 1'b0, 1'b0, 16'h0000, 8'hA1);
        chk(stackPointer, 8'h08);
        acc(`CMMD_K_DIRECT, 1'b0, 1'b0, 16'h0008, 8'h00);
        chk(rd, 8'hA1);
        acc(`CMMD_K_POP, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(rd, 8'hA1);
        rw(`CMMD_REG_STACK, 8'hFF);
        acc(`CMMD_K_PUSH, 1'b0, 1'b0, 16'h0000, 8'h5C);
        acc(`CMMD_K_DIRECT, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(rd, 8'h5C);
        $display("test stack done");
        for (b = 0; b < 4; b = b + 1) begin
            rw(`CMMD_REG_PWORD, {3'h0, b[1:0], 3'h0});
            acc(`CMMD_K_DIRECT, 1'b1, 1'b0, {11'h000, b[1:0], 3'h0}, {6'h10, b[1:0]});
            acc(`CMMD_K_DIRECT, 1'b1, 1'b0, {14'h0010, b[1:0]}, {6'h24, b[1:0]});
            acc(`CMMD_K_INDIRECT, 1'b0, 1'b0, 16'h0000, 8'h00);
            chk(rd, {6'h24, b[1:0]});
            acc(`CMMD_K_DIRECT, 1'b1, 1'b0, {11'h000, b[1:0], 3'h1}, {6'h30, b[1:0]});
            acc(`CMMD_K_INDIRECT, 1'b1, 1'b1, 16'h0000, {6'h0C, b[1:0]});
            acc(`CMMD_K_INDIRECT, 1'b0, 1'b1, 16'h0000, 8'h00);
            chk(rd, {6'h0C, b[1:0]});
        end
        acc(`CMMD_K_DIRECT, 1'b0, 1'b0, 16'h00C0, 8'h00);
        chk(rd, 8'h3F);
        $display("test banks done");
        acc(`CMMD_K_DIRECT, 1'b1, 1'b0, 16'h0022, 8'h00);
        acc(`CMMD_K_BIT, 1'b1, 1'b0, 16'h0013, 8'h01);
        acc(`CMMD_K_DIRECT, 1'b0, 1'b0, 16'h0022, 8'h00);
        chk(rd, 8'h08);
        acc(`CMMD_K_BIT, 1'b0, 1'b0, 16'h0013, 8'h00);
        chk(rd, 8'h01);
        acc(`CMMD_K_BIT, 1'b0, 1'b0, 16'h0014, 8'h00);
        chk(rd, 8'h00);
        acc(`CMMD_K_BIT, 1'b1, 1'b0, 16'h0093, 8'h00);
        acc(`CMMD_K_DIRECT, 1'b0, 1'b0, 16'h0090, 8'h00);
        chk(rd, 8'h67);
        acc(`CMMD_K_BIT, 1'b0, 1'b0, 16'h0092, 8'h00);
        chk(rd, 8'h01);
        acc(`CMMD_K_BIT, 1'b0, 1'b0, 16'h0093, 8'h00);
        chk(rd, 8'h00);
        $display("test bits done");
        acc(`CMMD_K_XWIDE, 1'b1, 1'b0, 16'h0000, 8'h11);
        acc(`CMMD_K_XWIDE, 1'b1, 1'b0, 16'h02FF, 8'h22);
        acc(`CMMD_K_XWIDE, 1'b0, 1'b0, 16'h0400, 8'h00);
        chk(rd, 8'h11);
        acc(`CMMD_K_XWIDE, 1'b0, 1'b0, 16'hFEFF, 8'h00);
        chk(rd, 8'h22);
        acc(`CMMD_K_XWIDE, 1'b1, 1'b0, 16'h0300, 8'h77);
        acc(`CMMD_K_XWIDE, 1'b0, 1'b0, 16'hFF00, 8'h00);
        chk(rd, 8'h00);
        acc(`CMMD_K_XWIDE, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(rd, 8'h11);
        chk(flashBusy, 1'b0);
        rw(`CMMD_REG_PAGE, 8'hFF);
        rr(`CMMD_REG_PAGE);
        chk(rd, 8'h03);
        acc(`CMMD_K_XPAGED, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(rd, 8'h00);
        rw(`CMMD_REG_PAGE, 8'h01);
        acc(`CMMD_K_XPAGED, 1'b1, 1'b0, 16'h0000, 8'h9E);
        acc(`CMMD_K_XWIDE, 1'b0, 1'b0, 16'h0143, 8'h00);
        chk(rd, 8'h9E);
        $display("test external done");
        acc(`CMMD_K_CODE, 1'b0, 1'b0, 16'h4000, 8'h00);
        chk(rd, 8'h00);
        rr(3'h6);
        chk(rd, 8'h00);
        rw(`CMMD_REG_FLCTL, 8'h01);
        acc(`CMMD_K_XWIDE, 1'b1, 1'b0, 16'h1000, 8'h00);
        acc(`CMMD_K_XWIDE, 1'b1, 1'b0, 16'h3FFF, 8'h00);
        acc(`CMMD_K_CODE, 1'b0, 1'b0, 16'h1000, 8'h00);
        chk(rd, 8'h00);
        rr(`CMMD_REG_LOCK);
        chk(rd, 8'h00);
        acc(`CMMD_K_XWIDE, 1'b0, 1'b0, 16'h1000, 8'h00);
        chk(rd, 8'h11);
        rw(`CMMD_REG_FLCTL, 8'h02);
        acc(`CMMD_K_XWIDE, 1'b1, 1'b0, 16'h1000, 8'h00);
        rr(`CMMD_REG_STATUS);
        chk(rd, 8'h01);
        repeat (520) @(posedge mclk);
        rw(`CMMD_REG_FLCTL, 8'h00);
        acc(`CMMD_K_CODE, 1'b0, 1'b0, 16'h1000, 8'h00);
        chk(rd, `CMMD_ERASED);
        $display("test code done");
        summarize;
    end
endmodule // cmmd_decoder_tb

// [tb/cmmd_sfr_model.sv]
// Behavioural special function space facing the decoder
`timescale 1ns/1ps
module cmmd_space_model (
    // Clock
    input wire        mclk,
    // Special function space port
    input wire        sfsRd,
    input wire        sfsWr,
    input wire        sfsBitOp,
    input wire [2:0]  sfsBitIdx,
    input wire [7:0]  sfsAddr,
    input wire [7:0]  sfsWdata,
    output wire [7:0] sfsRdata
);
    reg [7:0] mem [0:127];
    integer   i;
    // Each byte starts as its inverted address
    initial begin
        for (i = 0; i < 128; i = i + 1) begin
            mem[i] = ~(8'h80 | i[7:0]);
        end
    end
    // Byte write, or read-modify-write of one bit
    always @(posedge mclk) begin
        if (sfsWr && sfsBitOp) begin
            mem[sfsAddr[6:0]][sfsBitIdx] <= sfsWdata[0];
        end else if (sfsWr) begin
            mem[sfsAddr[6:0]] <= sfsWdata;
        end
    end
    // Unselected lines show the inverse, never a stale match
    assign sfsRdata = sfsRd ? mem[sfsAddr[6:0]] : ~mem[sfsAddr[6:0]];
endmodule // cmmd_space_model

// [verilog/cmmd_decoder.v]
// Memory map decoder with program, internal, external and stack spaces
//
// Contract
// RULE1: Flash program memory is 16 kB, contiguous from 0x0000 to 0x3FFF.
// RULE2: Address 0x3FFF holds the lock byte; addresses above are reserved.
// RULE3: Code reads only via code read; flash-configured external moves write/erase.
// RULE4: Without flash configuration, external moves hit on-chip external RAM.
// RULE5: 256 internal bytes; lower 128 reachable directly and indirectly.
// RULE6: Above 0x7F, direct goes to special function space, indirect to upper RAM.
// RULE7: Bytes 0x00-0x1F form four banks; bank bits 4:3 choose one.
// RULE8: Indirect addresses come from working register zero or one of active bank.
// RULE9: Bytes 0x20-0x2F give bit addresses 0x00-0x7F, (b-0x20)*8+n.
// RULE10: Bit operand means single-bit access, byte operand means whole-byte access.
// RULE11: Push writes at pointer plus one, then increments the pointer.
// RULE12: Reset loads stack pointer with 0x07.
// RULE13: Stack may sit anywhere in 256 bytes, depth up to 256.
// RULE14: 768 external RAM bytes reached by wide pointer or 8-bit indirect.
// RULE15: 8-bit external moves take the high address byte from the page register.
// RULE16: External addresses 0x0300-0x03FF always read 0x00.
// RULE17: Wide external moves ignore upper six bits; 1 kB mirrors every 0x0400.
// RULE18: Bank value 0-3 places the bank at 0x00, 0x08, 0x10 or 0x18.
// RULE19: Page register holds two-bit page in bits 1:0; upper bits read zero.
// RULE20: Writes into the read-as-zero region and its mirrors are discarded.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "cmmd_defs.vh"

module cmmd_decoder (
    // Clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // Core access port
    input  wire        accReq,
    input  wire [2:0]  accKind,
    input  wire        accWrite,
    input  wire        accRegSel,
    input  wire [15:0] accAddr,
    input  wire [7:0]  accWdata,
    output reg  [7:0]  accRdata,
    output reg         accDone,
    // Special function space port
    output reg         sfsRd,
    output reg         sfsWr,
    output reg         sfsBitOp,
    output reg  [2:0]  sfsBitIdx,
    output reg  [7:0]  sfsAddr,
    output reg  [7:0]  sfsWdata,
    input  wire [7:0]  sfsRdata,
    // Register port
    input  wire [2:0]  regAddr,
    input  wire [7:0]  regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [7:0]  regRdata,
    // State
    output reg  [7:0]  stackPointer,
    output reg         flashBusy
);

    // ****************************************
    // Storage
    // ****************************************
    reg [7:0] flashMem [0:`CMMD_FLASH_BYTES-1];
    reg [7:0] iram     [0:`CMMD_IRAM_BYTES-1];
    reg [7:0] xmem     [0:`CMMD_XMEM_BYTES-1];

    // Control registers
    reg [1:0] extRamPageField;
    reg [1:0] bankSelect;
    reg       flashWriteEn;
    reg       flashEraseEn;
    reg [4:0] eraseSector;
    reg [8:0] eraseCount;
    reg       sfsPending;

    // ****************************************
    // Decode functions
    // ****************************************
    // Byte holding a bit of the bit region
    function [7:0] bitByte;
        input [7:0] bitAddr;
        begin
            bitByte = `CMMD_BITBASE + {4'h0, bitAddr[6:3]}; // [RULE9]
        end
    endfunction

    // External address in the read-as-zero page
    function isHole;
        input [9:0] xAddr;
        begin
            isHole = (xAddr[9:8] == `CMMD_XHOLE_PAGE);
        end
    endfunction

    // ****************************************
    // Address formation
    // ****************************************
    wire [7:0]  bankBase  = {3'h0, bankSelect, 3'h0};             // [RULE18]
    wire [7:0]  workAddr  = bankBase | {7'h00, accRegSel};        // [RULE7]
    wire [7:0]  workVal   = iram[workAddr];                       // [RULE8]
    wire [9:0]  xAddr     = (accKind == `CMMD_K_XPAGED) ?
                            {extRamPageField, workVal} :          // [RULE15]
                            accAddr[9:0];                         // [RULE17]
    wire [7:0]  stackNext = stackPointer + 8'h01;                 // [RULE13]
    wire [7:0]  bitAddr   = accAddr[7:0];
    wire [7:0]  bitLoc    = bitByte(bitAddr);
    wire [7:0]  bitCur    = iram[bitLoc];
    wire [13:0] flashAddr = accAddr[13:0];
    wire        flashIn   = (accAddr <= `CMMD_FLASH_TOP);         // [RULE2]
    wire        take      = accReq & ~sfsPending & ~flashBusy;
    wire        isX       = (accKind == `CMMD_K_XWIDE) | (accKind == `CMMD_K_XPAGED);
    wire        xToFlash  = isX & accWrite & (flashWriteEn | flashEraseEn);
    wire        xRamWr    = isX & accWrite & ~xToFlash & ~isHole(xAddr); // [RULE4] [RULE20]

    // Internal RAM write decode
    reg       iramWe;
    reg [7:0] iramAddr;
    reg [7:0] iramData;
    always @* begin
        iramWe   = 1'b0;
        iramAddr = 8'h00;
        iramData = accWdata;
        if (take) begin
            case (accKind)
                `CMMD_K_DIRECT: begin
                    iramWe   = accWrite & ~accAddr[7];                // [RULE6]
                    iramAddr = accAddr[7:0];                          // [RULE5]
                end
                `CMMD_K_INDIRECT: begin
                    iramWe   = accWrite;                              // [RULE6]
                    iramAddr = workVal;                               // [RULE8]
                end
                `CMMD_K_BIT: begin
                    iramWe   = accWrite & ~bitAddr[7];                // [RULE10]
                    iramAddr = bitLoc;
                    iramData = bitCur;
                    iramData[bitAddr[2:0]] = accWdata[0];             // [RULE9]
                end
                `CMMD_K_PUSH: begin
                    iramWe   = 1'b1;
                    iramAddr = stackNext;                             // [RULE11]
                end
                default: begin
                    iramWe   = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Memory writes
    // ****************************************
    // Internal and external RAM
    always @(posedge mclk) begin
        if (iramWe) begin
            iram[iramAddr] <= iramData;
        end
        if (take & xRamWr) begin
            xmem[xAddr] <= accWdata;                                  // [RULE14]
        end
    end

    // Flash programming clears bits; erase walks a 512-byte sector
    always @(posedge mclk) begin
        if (flashBusy) begin
            flashMem[{eraseSector, eraseCount}] <= `CMMD_ERASED;
        end else if (take & xToFlash & flashWriteEn & ~flashEraseEn & flashIn) begin
            flashMem[flashAddr] <= flashMem[flashAddr] & accWdata;   // [RULE3]
        end
    end

    // ****************************************
    // Erase sequencer
    // ****************************************
    always @(posedge mclk) begin
        if (sys_rst) begin
            flashBusy   <= 1'b0;
            eraseSector <= 5'h00;
            eraseCount  <= 9'h000;
        end else if (flashBusy) begin
            eraseCount <= eraseCount + 9'h001;
            if (eraseCount == `CMMD_SECTOR_LAST) begin
                flashBusy <= 1'b0;
            end
        end else if (take & xToFlash & flashEraseEn & flashIn) begin
            flashBusy   <= 1'b1;                                      // [RULE3]
            eraseSector <= flashAddr[13:9];
            eraseCount  <= 9'h000;
        end
    end

    // ****************************************
    // Access answer and stack pointer
    // ****************************************
    always @(posedge mclk) begin
        if (sys_rst) begin
            accRdata     <= 8'h00;
            accDone      <= 1'b0;
            sfsRd        <= 1'b0;
            sfsWr        <= 1'b0;
            sfsBitOp     <= 1'b0;
            sfsBitIdx    <= 3'h0;
            sfsAddr      <= 8'h00;
            sfsWdata     <= 8'h00;
            sfsPending   <= 1'b0;
            stackPointer <= `CMMD_STACK_RESET;                        // [RULE12]
        end else begin
            accDone <= 1'b0;
            sfsRd   <= 1'b0;
            sfsWr   <= 1'b0;
            if (sfsPending) begin
                // Read data of the special function space, one cycle late
                sfsPending <= 1'b0;
                accDone    <= 1'b1;
                accRdata   <= sfsBitOp ? {7'h00, sfsRdata[sfsBitIdx]} : sfsRdata;
            end else if (take) begin
                accDone  <= 1'b1;
                accRdata <= 8'h00;
                case (accKind)
                    `CMMD_K_DIRECT: begin
                        if (accAddr[7]) begin
                            sfsRd      <= ~accWrite;                  // [RULE6]
                            sfsWr      <= accWrite;
                            sfsBitOp   <= 1'b0;
                            sfsAddr    <= accAddr[7:0];
                            sfsWdata   <= accWdata;
                            sfsPending <= ~accWrite;
                            accDone    <= accWrite;
                        end else begin
                            accRdata <= iram[accAddr[7:0]];           // [RULE5]
                        end
                    end
                    `CMMD_K_INDIRECT: begin
                        accRdata <= iram[workVal];                    // [RULE6] [RULE8]
                    end
                    `CMMD_K_BIT: begin
                        if (bitAddr[7]) begin
                            sfsRd      <= ~accWrite;
                            sfsWr      <= accWrite;
                            sfsBitOp   <= 1'b1;
                            sfsBitIdx  <= bitAddr[2:0];
                            sfsAddr    <= {bitAddr[7:3], 3'h0};
                            sfsWdata   <= accWdata;
                            sfsPending <= ~accWrite;
                            accDone    <= accWrite;
                        end else begin
                            accRdata <= {7'h00, bitCur[bitAddr[2:0]]}; // [RULE10]
                        end
                    end
                    `CMMD_K_PUSH: begin
                        if (!(regWr && regAddr == `CMMD_REG_STACK)) begin
                            stackPointer <= stackNext;                // [RULE11]
                        end
                    end
                    `CMMD_K_POP: begin
                        accRdata <= iram[stackPointer];
                        if (!(regWr && regAddr == `CMMD_REG_STACK)) begin
                            stackPointer <= stackPointer - 8'h01;     // [RULE13]
                        end
                    end
                    `CMMD_K_CODE: begin
                        accRdata <= flashIn ? flashMem[flashAddr] : 8'h00; // [RULE1] [RULE3]
                    end
                    default: begin
                        // External moves read on-chip RAM, never flash
                        if (!accWrite && !isHole(xAddr)) begin
                            accRdata <= xmem[xAddr];                  // [RULE4] [RULE14]
                        end else begin
                            accRdata <= 8'h00;                        // [RULE16]
                        end
                    end
                endcase
            end
            if (regWr && regAddr == `CMMD_REG_STACK) begin
                stackPointer <= regWdata;                             // [RULE13]
            end
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    always @(posedge mclk) begin
        if (sys_rst) begin
            extRamPageField <= 2'h0;
            bankSelect      <= 2'h0;
            flashWriteEn    <= 1'b0;
            flashEraseEn    <= 1'b0;
            regRdata        <= 8'h00;
        end else begin
            if (regWr) begin
                case (regAddr)
                    `CMMD_REG_PAGE: begin
                        extRamPageField <= regWdata[1:0];             // [RULE19]
                    end
                    `CMMD_REG_PWORD: begin
                        bankSelect <= regWdata[`CMMD_PWORD_BANK_HI:`CMMD_PWORD_BANK_LO]; // [RULE7]
                    end
                    `CMMD_REG_FLCTL: begin
                        flashWriteEn <= regWdata[`CMMD_FL_WRITE];
                        flashEraseEn <= regWdata[`CMMD_FL_ERASE];
                    end
                    default: begin
                    end
                endcase
            end
            regRdata <= 8'h00;
            if (regRd) begin
                case (regAddr)
                    `CMMD_REG_PAGE:   regRdata <= {6'h00, extRamPageField}; // [RULE19]
                    `CMMD_REG_PWORD:  regRdata <= {3'h0, bankSelect, 3'h0};
                    `CMMD_REG_STACK:  regRdata <= stackPointer;
                    `CMMD_REG_FLCTL:  regRdata <= {6'h00, flashEraseEn, flashWriteEn};
                    `CMMD_REG_STATUS: regRdata <= {7'h00, flashBusy};
                    `CMMD_REG_LOCK:   regRdata <= flashMem[`CMMD_LOCK_ADDR]; // [RULE2]
                    default:          regRdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // cmmd_decoder

// [verilog/cmmd_defs.vh]
// Constants for the core memory map decoder
`ifndef CMMD_DEFS_VH
`define CMMD_DEFS_VH

// ****************************************
// Access kinds on the core port
// ****************************************
`define CMMD_K_DIRECT    3'h0
`define CMMD_K_INDIRECT  3'h1
`define CMMD_K_BIT       3'h2
`define CMMD_K_PUSH      3'h3
`define CMMD_K_POP       3'h4
`define CMMD_K_XWIDE     3'h5
`define CMMD_K_XPAGED    3'h6
`define CMMD_K_CODE      3'h7

// ****************************************
// Memory sizes and map points
// ****************************************
`define CMMD_FLASH_BYTES 16384
`define CMMD_FLASH_TOP   16'h3FFF
`define CMMD_LOCK_ADDR   14'h3FFF
`define CMMD_IRAM_BYTES  256
`define CMMD_XMEM_BYTES  768
`define CMMD_XHOLE_PAGE  2'h3
`define CMMD_BITBASE     8'h20
`define CMMD_STACK_RESET 8'h07
`define CMMD_ERASED      8'hFF
`define CMMD_SECTOR_LAST 9'h1FF

// ****************************************
// Register port offsets
// ****************************************
`define CMMD_REG_PAGE    3'h0
`define CMMD_REG_PWORD   3'h1
`define CMMD_REG_STACK   3'h2
`define CMMD_REG_FLCTL   3'h3
`define CMMD_REG_STATUS  3'h4
`define CMMD_REG_LOCK    3'h5

// ****************************************
// Field positions
// ****************************************
`define CMMD_PWORD_BANK_HI 4
`define CMMD_PWORD_BANK_LO 3
`define CMMD_FL_WRITE    0
`define CMMD_FL_ERASE    1
`define CMMD_ST_BUSY     0

`endif
